// >>> tone_host_port.sv
// host register port of the tone transceiver: registers, status and event pin
`timescale 1ns/1ps
`default_nettype none

module tone_host_port
    import tone_port_pkg::*;
#(
    parameter int BURST_CNT    = BURST_CYCLES,
    parameter int BURST_CP_CNT = BURST_CP_CYCLES
) (
    // clock and reset
    input  wire logic                      mclk,
    input  wire logic                      rstn,
    // host bus pins, strobes active low
    input  wire logic                      reg_select_line,
    input  wire logic                      wr_n,
    input  wire logic                      rd_n,
    input  wire logic                      cs_n,
    input  wire logic [3:0]                data_in,
    output logic      [3:0]                data_out,
    output logic                           data_oe,
    // open-drain event or progress pin
    output logic                           event_or_progress_pin_o,
    output logic                           event_or_progress_pin_oe,
    // receiver side, same clock domain
    input  wire tone_port_pkg::rx_evt_t    rx_evt,
    // tone generator side
    output tone_port_pkg::tone_ctl_t       tone_ctl,
    output logic                           rx_enable
);
    import tone_port_pkg::*;

    // synchronised pins
    logic [1:0] sel_s, wr_s, rd_s, cs_s;
    logic [3:0] data_s1, data_s2;
    host_req_t  req;
    logic       wr_q, rd_q;
    logic       wr_fall, rd_rise, rd_act;

    // registers
    logic [3:0] primary_control_q;
    logic [3:0] secondary_control_q;
    logic [3:0] tone_digit_out_q;
    logic [3:0] decoded_digit_in_q;
    logic       bank_pointer_bit_q;
    logic       tx_empty_q, rx_full_q, steer_q, irq_q;
    logic       start_q;
    logic       burst_tone, burst_done;

    // field views
    logic tone_out_enable, progress_mode_sel, irq_enable;
    logic burst_mode, test_mode;

    assign tone_out_enable   = primary_control_q[PC_TONE_OUT];
    assign progress_mode_sel = primary_control_q[PC_PROGRESS];
    assign irq_enable        = primary_control_q[PC_IRQ_EN];
    assign burst_mode        = !secondary_control_q[SC_BURST_N];
    assign test_mode         = secondary_control_q[SC_TEST];

    // two-flop synchronisers; only the second stage is read
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            sel_s   <= 2'h0;
            wr_s    <= 2'h0;
            rd_s    <= 2'h0;
            cs_s    <= 2'h0;
            data_s1 <= 4'h0;
            data_s2 <= 4'h0;
        end else begin
            sel_s   <= {sel_s[0], reg_select_line};
            wr_s    <= {wr_s[0], !wr_n};
            rd_s    <= {rd_s[0], !rd_n};
            cs_s    <= {cs_s[0], !cs_n};
            data_s1 <= data_in;
            data_s2 <= data_s1;
        end
    end

    assign req.sel   = sel_s[1];
    assign req.wr    = wr_s[1] && cs_s[1];
    assign req.rd    = rd_s[1] && cs_s[1];
    assign req.wdata = data_s2;

    // strobe edge tracking
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
        end else begin
            wr_q <= req.wr;
            rd_q <= req.rd;
        end
    end

    // write latches at strobe end, data then settled for two cycles
    assign wr_fall = wr_q && !req.wr;
    // status read ends: flags clear here, after the host has sampled
    assign rd_rise = rd_q && !req.rd && req.sel;
    assign rd_act  = rd_s[1] && cs_s[1];

    // digit register write
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tone_digit_out_q <= DIGIT_RESET;
            start_q          <= 1'b0;
        end else begin
            start_q <= 1'b0;
            if (wr_fall && req.sel == SEL_DIGIT) begin
                tone_digit_out_q <= req.wdata;
                start_q          <= 1'b1;
            end
        end
    end

    // shared control address, bank pointer picks the target
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            primary_control_q   <= PC_RESET;
            secondary_control_q <= SC_RESET;
            bank_pointer_bit_q  <= 1'b0;
        end else if (wr_fall && req.sel == SEL_CONTROL) begin
            if (bank_pointer_bit_q) begin
                secondary_control_q <= req.wdata;
                bank_pointer_bit_q  <= 1'b0;
            end else begin
                primary_control_q  <= req.wdata;
                bank_pointer_bit_q <= req.wdata[PC_BANK_PTR];
            end
        end
    end

    // receive path; off in progress mode only, burst mode alone leaves it on.
    // registered so the port leaves a flop; the one-cycle lag after a
    // mode write is far shorter than any receiver guard time, so no
    // digit can slip through in between
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rx_enable <= 1'b1;
        end else begin
            rx_enable <= !progress_mode_sel;
        end
    end

    // received digit holds the code unchanged, same as transmit code
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            decoded_digit_in_q <= DIGIT_RESET;
        end else if (rx_evt.digit_valid && rx_enable) begin
            decoded_digit_in_q <= rx_evt.digit;
        end
    end

    // status flags: a new event wins over the read clear
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tx_empty_q <= 1'b0;
            rx_full_q  <= 1'b0;
        end else begin
            if (!burst_mode) begin
                tx_empty_q <= 1'b0;
            end else if (burst_done) begin
                tx_empty_q <= 1'b1;
            end else if (rd_rise) begin
                tx_empty_q <= 1'b0;
            end
            if (rx_evt.digit_valid && rx_enable) begin
                rx_full_q <= 1'b1;
            end else if (rd_rise) begin
                rx_full_q <= 1'b0;
            end
        end
    end

    // summary flag, set by either event, cleared by read
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irq_q <= 1'b0;
        end else if ((burst_mode && burst_done) ||
                     (rx_evt.digit_valid && rx_enable)) begin
            irq_q <= 1'b1;
        end else if (rd_rise) begin
            irq_q <= 1'b0;
        end
    end

    // delayed steering: absence sets, valid tone clears
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            steer_q <= 1'b1;
        end else if (rx_evt.steer_absent) begin
            steer_q <= 1'b1;
        end else if (rx_evt.steer_present) begin
            steer_q <= 1'b0;
        end
    end

    // read data driven while the read strobe is held
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            data_out <= 4'h0;
            data_oe  <= 1'b0;
        end else begin
            data_oe <= rd_act;
            if (req.sel == SEL_CONTROL) begin
                data_out <= {steer_q, rx_full_q, tx_empty_q, irq_q};
            end else begin
                data_out <= decoded_digit_in_q;
            end
        end
    end

    // burst sequencer
    burst_timer #(
        .BURST_CNT    (BURST_CNT),
        .BURST_CP_CNT (BURST_CP_CNT)
    ) u_burst (
        .mclk      (mclk),
        .rstn      (rstn),
        .start     (start_q),
        .long_mode (progress_mode_sel),
        .active    (burst_mode),
        .tone_on   (burst_tone),
        .done      (burst_done)
    );

    // tone generator controls; enable bit gates both modes
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tone_ctl <= '0;
        end else begin
            tone_ctl.digit  <= tone_digit_out_q;
            tone_ctl.single <= secondary_control_q[SC_SINGLE];
            tone_ctl.column <= secondary_control_q[SC_COLUMN];
            if (burst_mode) begin
                tone_ctl.enable <= tone_out_enable && burst_tone;
            end else begin
                tone_ctl.enable <= tone_out_enable;
            end
        end
    end

    // pin: only ever pulled low, output data held at zero
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            event_or_progress_pin_o  <= 1'b0;
            event_or_progress_pin_oe <= 1'b0;
        end else begin
            event_or_progress_pin_o <= 1'b0;
            if (test_mode && !progress_mode_sel) begin
                event_or_progress_pin_oe <= !steer_q;
            end else if (progress_mode_sel) begin
                event_or_progress_pin_oe <= irq_enable && !rx_evt.cp_wave;
            end else begin
                event_or_progress_pin_oe <= irq_enable && irq_q;
            end
        end
    end

endmodule : tone_host_port
`default_nettype wire

// >>> tone_port_pkg.sv
// shared constants and carrier types for the tone transceiver host port
package tone_port_pkg;

    // register select values
    localparam logic       SEL_DIGIT       = 1'b0;
    localparam logic       SEL_CONTROL     = 1'b1;

    // primary_control field positions
    localparam int         PC_TONE_OUT     = 0;
    localparam int         PC_PROGRESS     = 1;
    localparam int         PC_IRQ_EN       = 2;
    localparam int         PC_BANK_PTR     = 3;

    // secondary_control field positions
    localparam int         SC_BURST_N      = 0;
    localparam int         SC_TEST         = 1;
    localparam int         SC_SINGLE       = 2;
    localparam int         SC_COLUMN       = 3;

    // transceiver_state field positions
    localparam int         ST_IRQ          = 0;
    localparam int         ST_TX_EMPTY     = 1;
    localparam int         ST_RX_FULL      = 2;
    localparam int         ST_DELAY_STEER  = 3;

    // reset values
    localparam logic [3:0] PC_RESET        = 4'h0;
    localparam logic [3:0] SC_RESET        = 4'h1;
    localparam logic [3:0] DIGIT_RESET     = 4'h0;

    // timing
    localparam int         CLK_HZ          = 50_000_000;
    localparam int         BURST_MS        = 51;
    localparam int         BURST_CP_MS     = 102;
    localparam int         BURST_CYCLES    = BURST_MS * (CLK_HZ / 1000);
    localparam int         BURST_CP_CYCLES = BURST_CP_MS * (CLK_HZ / 1000);

    // host strobe group, all active high after synchronising
    typedef struct packed {
        logic       sel;
        logic       wr;
        logic       rd;
        logic [3:0] wdata;
    } host_req_t;

    // tone generator controls
    typedef struct packed {
        logic       enable;
        logic       single;
        logic       column;
        logic [3:0] digit;
    } tone_ctl_t;

    // receiver events and levels
    typedef struct packed {
        logic       digit_valid;
        logic [3:0] digit;
        logic       steer_absent;
        logic       steer_present;
        logic       cp_wave;
    } rx_evt_t;

endpackage : tone_port_pkg

// >>> burst_timer.sv
// burst and pause sequencer for the transmit path
`timescale 1ns/1ps
`default_nettype none
module burst_timer
    import tone_port_pkg::*;
#(
    parameter int BURST_CNT    = BURST_CYCLES,
    parameter int BURST_CP_CNT = BURST_CP_CYCLES
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rstn,
    // control
    input  wire logic start,
    input  wire logic long_mode,
    input  wire logic active,
    // status
    output logic      tone_on,
    output logic      done
);
    typedef enum logic [1:0] {IDLE, BURST, PAUSE} phase_t;

    phase_t      phase_q;
    logic [27:0] cnt_q;
    logic [27:0] span;

    // period taken every cycle from the current mode, not fixed at phase start
    assign span = long_mode ? 28'(BURST_CP_CNT - 1) : 28'(BURST_CNT - 1);

    // burst then equal pause, then one done pulse
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            phase_q <= IDLE;
            cnt_q   <= 28'h0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (!active) begin
                phase_q <= IDLE; // leaving burst mode abandons a burst
            end else begin
                unique case (phase_q)
                    IDLE: begin
                        if (start) begin
                            phase_q <= BURST;
                            cnt_q   <= 28'h0;
                        end
                    end
                    BURST: begin
                        cnt_q <= cnt_q + 28'h1;
                        if (cnt_q >= span) begin
                            phase_q <= PAUSE;
                            cnt_q   <= 28'h0;
                        end
                    end
                    PAUSE: begin
                        cnt_q <= cnt_q + 28'h1;
                        if (cnt_q >= span) begin
                            phase_q <= IDLE;
                            done    <= 1'b1;
                        end
                    end
                    default: phase_q <= IDLE;
                endcase
            end
        end
    end

    // tone only sounds during the burst phase; the start edge counts as
    // the first burst cycle, so the last count value must drop the tone
    // to keep burst and pause the same length
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tone_on <= 1'b0;
        end else begin
            tone_on <= active && ((phase_q == BURST && cnt_q < span) ||
                       (phase_q == IDLE && start));
        end
    end
endmodule : burst_timer
`default_nettype wire

// >>> tone_host_port_monitor.sv
// pin-level checker for the tone host port
`timescale 1ns/1ps
`default_nettype none
module tone_host_port_monitor
    import tone_port_pkg::*;
#(
    parameter int BURST_CNT    = 20,
    parameter int BURST_CP_CNT = 40
) (
    // clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rstn,
    // host bus
    input  wire logic                   reg_select_line,
    input  wire logic                   wr_n,
    input  wire logic                   rd_n,
    input  wire logic                   cs_n,
    input  wire logic [3:0]             data_in,
    input  wire logic [3:0]             data_out,
    input  wire logic                   data_oe,
    // event pin
    input  wire logic                   event_or_progress_pin_o,
    input  wire logic                   event_or_progress_pin_oe,
    // receiver and generator sides
    input  wire tone_port_pkg::rx_evt_t rx_evt,
    input  wire tone_port_pkg::tone_ctl_t tone_ctl,
    input  wire logic                   rx_enable
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    // read strobe held long enough to pass the synchronisers
    sequence rd_held;
        (!rd_n && !cs_n) [*4];
    endsequence
    // no write strobe for a while, so nothing may move
    sequence wr_quiet;
        wr_n [*8];
    endsequence

    pin_low_only_a: assert property (event_or_progress_pin_o == 1'b0)
        else $error("event pin driven high");
    rd_answer_a: assert property (rd_held |-> data_oe)
        else $error("read data not driven in time");
    rd_release_a: assert property (rd_n [*4] |-> !data_oe)
        else $error("read data still driven after strobe");
    rd_hold_a: assert property (rd_held ##1 (!rd_n && !cs_n) |-> $stable(data_out))
        else $error("read data moved during strobe");
    cp_follow_a: assert property ((!rx_enable && rx_evt.cp_wave) [*2]
        |-> !event_or_progress_pin_oe)
        else $error("pin low while progress wave high");
    digit_hold_a: assert property (wr_quiet |=> $stable(tone_ctl.digit))
        else $error("tone digit changed without write");
    mode_hold_a: assert property (wr_quiet |=> $stable({tone_ctl.single, tone_ctl.column}))
        else $error("tone mode changed without write");
    rxen_hold_a: assert property (wr_quiet |=> $stable(rx_enable))
        else $error("receive enable changed without write");
    tone_gate_a: assert property (wr_quiet ##0 !tone_ctl.enable |=> !tone_ctl.enable)
        else $error("tone started without write");
endmodule : tone_host_port_monitor

bind tone_host_port tone_host_port_monitor #(
    .BURST_CNT(BURST_CNT), .BURST_CP_CNT(BURST_CP_CNT)
) mon_u (
    .mclk(mclk), .rstn(rstn), .reg_select_line(reg_select_line), .wr_n(wr_n),
    .rd_n(rd_n), .cs_n(cs_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .event_or_progress_pin_o(event_or_progress_pin_o),
    .event_or_progress_pin_oe(event_or_progress_pin_oe),
    .rx_evt(rx_evt), .tone_ctl(tone_ctl), .rx_enable(rx_enable)
);
`default_nettype wire

// >>> tone_host_model.sv
// host controller model driving the register strobes
`timescale 1ns/1ps
`default_nettype none
module tone_host_model (
    // clock
    input  wire logic       mclk,
    // bus pins toward the port
    output logic            sel,
    output logic            wr_n,
    output logic            rd_n,
    output logic            cs_n,
    output logic [3:0]      wdata,
    // read return
    input  wire logic [3:0] rdata
);
    int hold = 4;  // strobe and gap length; raise it for a slow host

    // idle bus at time zero
    initial begin
        sel = 1'b0;
        wr_n = 1'b1;
        rd_n = 1'b1;
        cs_n = 1'b1;
        wdata = 4'h5;
    end

    // one write; data outlives the strobe, then shows junk
    task automatic wr(input logic s, input logic [3:0] d);
        @(negedge mclk);
        sel = s;
        cs_n = 1'b0;
        wr_n = 1'b0;
        wdata = d;
        repeat (hold) @(negedge mclk);
        wr_n = 1'b1;
        repeat (hold) @(negedge mclk);
        cs_n = 1'b1;
        wdata = ~d;
    endtask : wr

    // one read; data taken at the last strobe cycle
    task automatic rd(input logic s, output logic [3:0] q);
        @(negedge mclk);
        sel = s;
        cs_n = 1'b0;
        rd_n = 1'b0;
        repeat (hold) @(negedge mclk);
        q = rdata;
        rd_n = 1'b1;
        repeat (hold) @(negedge mclk);
        cs_n = 1'b1;
    endtask : rd
endmodule : tone_host_model
`default_nettype wire

// >>> dtmf_host_register_port_tb_top.sv
// self-checking bench for the tone host port
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %s exp %h got %h", n, e, g); end end
module dtmf_host_register_port_tb_top;
    import tone_port_pkg::*;
    localparam int BC  = 20;
    localparam int BCP = 40;
    logic       mclk;
    logic       rstn;
    logic       sel;
    logic       wr_n;
    logic       rd_n;
    logic       cs_n;
    logic [3:0] wdata;
    logic [3:0] rdata;
    logic [3:0] q;
    logic       data_oe;
    logic       pin_oe;
    rx_evt_t    rx_evt;
    tone_ctl_t  tone_ctl;
    logic       rx_enable;
    int         run = 0;
    int         last_run = 0;
    int         error_cnt = 0;
    int         checked = 0;
    // {digit in, digit expected}
    logic [7:0] rows [4] = '{8'h00, 8'h77, 8'haa, 8'hff};

    tone_host_model host_u (.mclk(mclk), .sel(sel), .wr_n(wr_n), .rd_n(rd_n),
        .cs_n(cs_n), .wdata(wdata), .rdata(rdata));
    tone_host_port #(.BURST_CNT(BC), .BURST_CP_CNT(BCP)) dut_u (
        .mclk(mclk), .rstn(rstn), .reg_select_line(sel), .wr_n(wr_n), .rd_n(rd_n),
        .cs_n(cs_n), .data_in(wdata), .data_out(rdata), .data_oe(data_oe),
        .event_or_progress_pin_o(), .event_or_progress_pin_oe(pin_oe),
        .rx_evt(rx_evt), .tone_ctl(tone_ctl), .rx_enable(rx_enable));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // length of the latest tone stretch
    always @(posedge mclk) begin
        if (tone_ctl.enable === 1'b1) begin
            run <= run + 1;
        end else if (run != 0) begin
            last_run <= run;
            run <= 0;
        end
    end

    task automatic end_of_test();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    // write, then let the register settle
    task automatic w(input logic s, input logic [3:0] d);
        host_u.wr(s, d);
        repeat (3) @(negedge mclk);
    endtask : w

    // pointer, secondary, primary in that order
    task automatic wb(input logic [3:0] b, input logic [3:0] a);
        w(1'b1, 4'h8);
        w(1'b1, b);
        w(1'b1, a);
    endtask : wb

    task automatic rdc(input logic s, input logic [3:0] m, input logic [3:0] e);
        host_u.rd(s, q);
        `CHK("read", e, q & m)
    endtask : rdc

    // one-cycle receiver event; digit field junk afterwards
    task automatic pulse(input logic [6:0] e);
        @(negedge mclk);
        rx_evt[7:1] = e;
        @(negedge mclk);
        rx_evt[7:1] = {1'b0, ~e[5:2], 2'b00};
        repeat (3) @(negedge mclk);
    endtask : pulse

    task automatic wait_pin();
        for (int k = 0; k < 400 && pin_oe !== 1'b1; k++) @(negedge mclk);
    endtask : wait_pin

    initial begin
        #(20 * 20000);
        error_cnt++;
        $display("[FAIL] watchdog exp done got hang");
        end_of_test();
    end

    initial begin
        rstn = 1'b0;
        rx_evt = '0;
        repeat (2) @(negedge mclk);
        rstn = 1'b1;
        `CHK("tone_ctl", 7'h00, tone_ctl)
        `CHK("rx_enable", 1'b1, rx_enable)
        rdc(1'b1, 4'hf, 4'h8);
        // power-up software reset
        w(1'b1, 4'h0);
        w(1'b1, 4'h0);
        w(1'b1, 4'h8);
        w(1'b1, 4'h0);
        host_u.rd(1'b1, q);
        wb(4'h1, 4'h1);
        for (int i = 0; i < 4; i++) begin
            w(1'b0, rows[i][7:4]);
            `CHK("tx digit", rows[i][3:0], tone_ctl.digit)
            `CHK("tone on", 1'b1, tone_ctl.enable)
            pulse({1'b1, rows[i][7:4], 2'b01});
            rdc(1'b0, 4'hf, rows[i][3:0]);
            rdc(1'b1, 4'h7, 4'h5);
        end
        rdc(1'b1, 4'h7, 4'h0);
        w(1'b1, 4'h0);
        `CHK("tone off", 1'b0, tone_ctl.enable)
        for (int i = 0; i < 4; i++) begin
            wb({i[1:0], 2'b01}, 4'h0);
            `CHK("tone mode", {i[0], i[1]}, {tone_ctl.single, tone_ctl.column})
        end
        // interrupt on a received digit
        wb(4'h1, 4'h4);
        pulse({1'b1, 4'h9, 2'b01});
        `CHK("pin", 1'b1, pin_oe)
        rdc(1'b1, 4'hf, 4'h5);
        `CHK("pin", 1'b0, pin_oe)
        pulse(7'h02);
        rdc(1'b1, 4'hf, 4'h8);
        // test mirror of the steering flag
        wb(4'h3, 4'h0);
        `CHK("pin", 1'b0, pin_oe)
        pulse(7'h01);
        `CHK("pin", 1'b1, pin_oe)
        pulse(7'h02);
        // progress mode
        wb(4'h1, 4'h6);
        `CHK("rx_enable", 1'b0, rx_enable)
        pulse({1'b1, 4'h2, 2'b01});
        rdc(1'b1, 4'h4, 4'h0);
        rx_evt.cp_wave = 1'b0;
        repeat (3) @(negedge mclk);
        `CHK("pin", 1'b1, pin_oe)
        rx_evt.cp_wave = 1'b1;
        repeat (3) @(negedge mclk);
        `CHK("pin", 1'b0, pin_oe)
        // timed bursts, normal then long
        wb(4'h0, 4'h5);
        w(1'b0, 4'h3);
        wait_pin();
        `CHK("burst", BC, last_run)
        `CHK("pin", 1'b1, pin_oe)
        rdc(1'b1, 4'h3, 4'h3);
        host_u.hold = 6;
        wb(4'h0, 4'h7);
        w(1'b0, 4'hc);
        pulse({1'b1, 4'h4, 2'b01});
        wait_pin();
        `CHK("burst", BCP, last_run)
        rdc(1'b1, 4'h7, 4'h3);
        end_of_test();
    end
endmodule : dtmf_host_register_port_tb_top
`default_nettype wire
